// ===== rtl/input_function_dispatcher.sv
// Top of the input function dispatcher with its AXI4-Lite register slave
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
module input_function_dispatcher
    import input_dispatch_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = RESTART_HOLD_CYC
) (
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire axil_req_s            axil_req_i,
    output axil_rsp_s                 axil_rsp_o,
    input  wire logic [NUM_PORTS-1:0] in_port_i,
    input  wire logic                 auto_mode_i,
    input  wire logic                 io_board_err_i,
    output logic                      io_err_o,
    output logic                      servo_on_o,
    output logic                      program_run_o,
    output logic                      paused_o,
    output logic                      restart_o,
    output logic                      error_clear_o,
    output logic                      home_start_o
);

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        logic [1:0]  ctrl;
        logic [63:0] fsel;
        logic        servo;
        logic        run;
        logic        paused;
        logic        launch_pend;
        logic        err_clr;
        logic        home;
        logic        restart;
        logic        io_err;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } disp_s;

    disp_s q, d;

    logic [NUM_PORTS-1:0] lvl, rise, fall;
    logic [NUM_PORTS-1:0] m_rst, m_sv, m_st, m_pa, m_pr, m_ec, m_hm;
    logic                 restart_fire;
    logic                 start_en;
    logic                 wr_go, rd_go;

    // ********************************************************************
    // Input sampling and restart qualification
    // ********************************************************************
    port_sync u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .in_i      (in_port_i),
        .level_o   (lvl),
        .rise_o    (rise),
        .fall_o    (fall)
    );

    hold_timer #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_hold (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .level_i   (|(lvl & m_rst)),
        .fire_o    (restart_fire)
    );

    // Unassigned codes match no mask, so their ports stay inert
    assign m_rst = fn_mask(q.fsel, FN_RESTART);
    assign m_sv  = fn_mask(q.fsel, FN_SERVO);
    assign m_st  = fn_mask(q.fsel, FN_START);
    assign m_pa  = fn_mask(q.fsel, FN_PAUSE);
    assign m_pr  = fn_mask(q.fsel, FN_RELEASE);
    assign m_ec  = fn_mask(q.fsel, FN_ERR_CLR);
    assign m_hm  = fn_mask(q.fsel, FN_HOME);

    assign start_en = !q.ctrl[CTRL_AUTO_BIT];

    // One write and one read at a time; address and data are taken together
    assign wr_go = axil_req_i.awvalid && axil_req_i.wvalid && !q.bvalid;
    assign rd_go = axil_req_i.arvalid && !q.rvalid;

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        d         = q;
        d.err_clr = 1'b0;
        d.home    = 1'b0;
        d.restart = 1'b0;

        d.io_err = io_board_err_i && q.ctrl[CTRL_MON_BIT];

        if (|(rise & m_sv)) begin
            d.servo = 1'b1;
        end else if (|(fall & m_sv)) begin
            d.servo = 1'b0;
        end

        if (start_en && |(rise & m_st)) begin
            d.run = 1'b1;
        end else if (start_en && |(fall & m_st)) begin
            d.run = 1'b0;
        end

        // Launch is judged once, in the cycle after reset or restart
        if (q.launch_pend) begin
            d.launch_pend = 1'b0;
            if (q.ctrl[CTRL_AUTO_BIT] && auto_mode_i) begin
                d.run = 1'b1;
            end
        end

        // A pause request beats a release arriving in the same cycle
        if (|(fall & m_pa)) begin
            d.paused = 1'b1;
        end else if (|(rise & m_pr)) begin
            d.paused = 1'b0;
        end

        d.err_clr = |(rise & m_ec);
        // Homing without servo would fault the axis, so it is dropped
        d.home    = |(rise & m_hm) && q.servo;

        if (restart_fire) begin
            d.servo       = 1'b0;
            d.run         = 1'b0;
            d.paused      = 1'b0;
            d.err_clr     = 1'b0;
            d.home        = 1'b0;
            d.launch_pend = 1'b1;
            d.restart     = 1'b1;
        end

        // Register writes
        if (q.bvalid && axil_req_i.bready) begin
            d.bvalid = 1'b0;
        end
        if (wr_go) begin
            d.bvalid = 1'b1;
            d.bresp  = RESP_OKAY;
            case (axil_req_i.awaddr[7:2])
                ADDR_CTRL[7:2]: begin
                    if (axil_req_i.wstrb[0]) begin
                        d.ctrl = axil_req_i.wdata[1:0];
                    end
                end
                ADDR_FSEL_LO[7:2]: begin
                    d.fsel[31:0] = merge_strb(q.fsel[31:0], axil_req_i.wdata,
                                              axil_req_i.wstrb);
                end
                ADDR_FSEL_HI[7:2]: begin
                    d.fsel[63:32] = merge_strb(q.fsel[63:32], axil_req_i.wdata,
                                               axil_req_i.wstrb);
                end
                ADDR_STATUS[7:2]: begin
                    d.bresp = RESP_OKAY;
                end
                default: begin
                    d.bresp = RESP_SLVERR;
                end
            endcase
        end

        // Register reads
        if (q.rvalid && axil_req_i.rready) begin
            d.rvalid = 1'b0;
        end
        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            d.rdata  = 32'h0;
            case (axil_req_i.araddr[7:2])
                ADDR_CTRL[7:2]: begin
                    d.rdata[1:0] = q.ctrl;
                end
                ADDR_FSEL_LO[7:2]: begin
                    d.rdata = q.fsel[31:0];
                end
                ADDR_FSEL_HI[7:2]: begin
                    d.rdata = q.fsel[63:32];
                end
                ADDR_STATUS[7:2]: begin
                    d.rdata[ST_SERVO_BIT]  = q.servo;
                    d.rdata[ST_RUN_BIT]    = q.run;
                    d.rdata[ST_PAUSE_BIT]  = q.paused;
                    d.rdata[ST_LAUNCH_BIT] = q.launch_pend;
                    d.rdata[ST_IOERR_BIT]  = q.io_err;
                    d.rdata[ST_LEVEL_POS +: NUM_PORTS] = lvl;
                end
                default: begin
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q             <= '0;
            q.ctrl        <= CTRL_RESET;
            q.fsel        <= FSEL_RESET;
            q.launch_pend <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign io_err_o      = q.io_err;
    assign servo_on_o    = q.servo;
    assign program_run_o = q.run;
    assign paused_o      = q.paused;
    assign restart_o     = q.restart;
    assign error_clear_o = q.err_clr;
    assign home_start_o  = q.home;

    assign axil_rsp_o.awready = wr_go;
    assign axil_rsp_o.wready  = wr_go;
    assign axil_rsp_o.bvalid  = q.bvalid;
    assign axil_rsp_o.bresp   = q.bresp;
    assign axil_rsp_o.arready = rd_go;
    assign axil_rsp_o.rvalid  = q.rvalid;
    assign axil_rsp_o.rdata   = q.rdata;
    assign axil_rsp_o.rresp   = q.rresp;

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_monitor_off_mute: assert property (
        !q.ctrl[CTRL_MON_BIT] |=> !io_err_o)
        else $error("board error shown while monitor disabled");

    a_servo_edge_follow: assert property (
        |(rise & m_sv) && !restart_fire |=> servo_on_o)
        else $error("servo not on after enable rise");

    a_servo_off_edge: assert property (
        |(fall & m_sv) && !(|(rise & m_sv)) |=> !servo_on_o)
        else $error("servo not off after enable fall");

    a_run_start_cause: assert property (
        $rose(program_run_o) |-> $past(start_en && |(rise & m_st)) || $past(q.launch_pend))
        else $error("program started without a cause");

    a_pause_on_fall: assert property (
        |(fall & m_pa) |=> paused_o || $past(restart_fire))
        else $error("pause input fall did not pause");

    a_release_clears: assert property (
        $fell(paused_o) |-> $past(|(rise & m_pr)) || $past(restart_fire))
        else $error("pause released without release edge");

    a_err_clear_pulse: assert property (
        |(rise & m_ec) && !restart_fire |=> error_clear_o ##1
        (!error_clear_o || $past(|(rise & m_ec))))
        else $error("error clear pulse missing");

    a_home_needs_servo: assert property (
        home_start_o |-> $past(servo_on_o) && $past(|(rise & m_hm)))
        else $error("home start without servo or edge");

    a_restart_cleans: assert property (
        restart_fire |=> restart_o && !servo_on_o && !paused_o ##1 !restart_o)
        else $error("restart did not clear control state");

    a_unassigned_inert: assert property (
        m_sv == '0 && !restart_fire |=> $stable(servo_on_o))
        else $error("servo moved with no enable port assigned");

    a_write_answer: assert property (
        wr_go |=> axil_rsp_o.bvalid)
        else $error("write not answered next cycle");

    c_servo_on:   cover property ($rose(servo_on_o));
    c_pause:      cover property ($rose(paused_o) ##[1:50] $fell(paused_o));
    c_restart:    cover property (restart_o);
    c_auto_start: cover property (q.launch_pend ##1 program_run_o);

endmodule : input_function_dispatcher

// ===== rtl/input_dispatch_pkg.sv
// Package of constants, carriers and helpers for the input function dispatcher
package input_dispatch_pkg;

    // ********************************************************************
    // Sizes and timing
    // ********************************************************************
    localparam int unsigned NUM_PORTS      = 8;
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned RESTART_HOLD_MS = 1000;
    localparam int unsigned RESTART_HOLD_CYC = RESTART_HOLD_MS * 1000 * CLK_MHZ;

    // ********************************************************************
    // Register map (byte addresses)
    // ********************************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_FSEL_LO = 8'h04;
    localparam logic [7:0] ADDR_FSEL_HI = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;

    localparam int unsigned CTRL_MON_BIT  = 0;
    localparam int unsigned CTRL_AUTO_BIT = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h3;
    localparam logic [63:0] FSEL_RESET    = 64'h0;

    localparam int unsigned ST_SERVO_BIT  = 0;
    localparam int unsigned ST_RUN_BIT    = 1;
    localparam int unsigned ST_PAUSE_BIT  = 2;
    localparam int unsigned ST_LAUNCH_BIT = 3;
    localparam int unsigned ST_IOERR_BIT  = 4;
    localparam int unsigned ST_LEVEL_POS  = 8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ********************************************************************
    // Input function codes
    // ********************************************************************
    localparam logic [7:0] FN_RESTART = 8'h03;
    localparam logic [7:0] FN_SERVO   = 8'h04;
    localparam logic [7:0] FN_START   = 8'h05;
    localparam logic [7:0] FN_PAUSE   = 8'h07;
    localparam logic [7:0] FN_RELEASE = 8'h08;
    localparam logic [7:0] FN_ERR_CLR = 8'h10;
    localparam logic [7:0] FN_HOME    = 8'h12;

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axil_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_s;

    // Ports whose function selection holds the given code
    function automatic logic [NUM_PORTS-1:0] fn_mask(input logic [63:0] fsel,
                                                     input logic [7:0]  code);
        logic [NUM_PORTS-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            m[i] = (fsel[8*i +: 8] == code);
        end
        return m;
    endfunction : fn_mask

    // Byte-lane merge of a write into a register word
    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] wdata,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = wdata[8*b +: 8];
            end
        end
        return r;
    endfunction : merge_strb

endpackage : input_dispatch_pkg

// ===== rtl/port_sync.sv
// Two-flop synchroniser and edge detector for the input ports
module port_sync
    import input_dispatch_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic [NUM_PORTS-1:0] in_i,
    output logic      [NUM_PORTS-1:0] level_o,
    output logic      [NUM_PORTS-1:0] rise_o,
    output logic      [NUM_PORTS-1:0] fall_o
);

    typedef struct packed {
        logic [NUM_PORTS-1:0] meta;
        logic [NUM_PORTS-1:0] sync;
        logic [NUM_PORTS-1:0] prev;
    } sync_s;

    sync_s q, d;

    always_comb begin
        d      = q;
        d.meta = in_i;
        d.sync = q.meta;
        d.prev = q.sync;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Edges compare successive synchronised samples only
    assign level_o = q.sync;
    assign rise_o  = q.sync & ~q.prev;
    assign fall_o  = ~q.sync & q.prev;

    a_rise_follows_input: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rise_o[0] |-> $past(in_i[0], 2) && !$past(in_i[0], 3))
        else $error("rise flag without a sampled rising input");

endmodule : port_sync

// ===== rtl/hold_timer.sv
// Continuous-hold qualifier that fires once after a level stays high long enough
module hold_timer
    import input_dispatch_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = RESTART_HOLD_CYC
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic level_i,
    output logic      fire_o
);

    typedef struct packed {
        logic [31:0] cnt;
        logic        done;
        logic        fire;
    } hold_s;

    hold_s q, d;

    always_comb begin
        d      = q;
        d.fire = 1'b0;
        if (!level_i) begin
            // Any drop restarts the count, so short pulses never fire
            d.cnt  = '0;
            d.done = 1'b0;
        end else if (!q.done) begin
            if (q.cnt == 32'(HOLD_CYCLES - 1)) begin
                d.fire = 1'b1;
                d.done = 1'b1;
            end else begin
                d.cnt = q.cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign fire_o = q.fire;

    a_fire_once_held: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        fire_o |-> $past(level_i) && q.cnt == 32'(HOLD_CYCLES - 1) ##1 !fire_o)
        else $error("hold fire without full hold or repeated");

endmodule : hold_timer

// ===== verification/host_panel.sv
// Behavioural model of the host switch panel that drives the input ports
module host_panel #(
    parameter int unsigned HOME_IDX = 1
) (
    input  wire logic       clk_i,
    input  wire logic [7:0] want_i,
    input  wire logic       servo_on_i,
    input  wire logic       rogue_i,
    output logic      [7:0] port_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Port levels
    // ****************************************************************
    initial begin
        port_o = 8'h00;
    end

    // A careful host never asks for homing with the servo off;
    // rogue_i lets a scenario break that on purpose
    // One assignment per edge, with the homing bit gated in place
    always @(posedge clk_i) begin
        port_o <= want_i & ~(8'h01 << HOME_IDX)
                  | ({7'h00, want_i[HOME_IDX] & (servo_on_i | rogue_i)} << HOME_IDX);
    end
endmodule : host_panel

// ===== verification/input_function_dispatcher_tb.sv
// Self-checking testbench of the input function dispatcher
module input_function_dispatcher_tb;
    import input_dispatch_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clk_i;
    logic        sys_rst_i;
    axil_req_s   req;
    axil_rsp_s   rsp;
    logic [7:0]  want;
    logic [7:0]  port;
    logic        auto_mode;
    logic        board_err;
    logic        rogue;
    logic        io_err, servo, run, paused, rst_p, clr_p, home_p;
    logic [6:0]  ov;
    logic [6:0]  prev = 7'h00;
    logic [33:0] eq[$];
    logic [33:0] bq[$];
    logic [33:0] rq[$];
    int          n_errors = 0;
    int          check_count = 0;
    int          seed = 32'h9c76;

    assign ov = {io_err, servo, run, paused, rst_p, clr_p, home_p};

    input_function_dispatcher #(.HOLD_CYCLES(20)) dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .axil_req_i(req), .axil_rsp_o(rsp),
        .in_port_i(port), .auto_mode_i(auto_mode), .io_board_err_i(board_err),
        .io_err_o(io_err), .servo_on_o(servo), .program_run_o(run),
        .paused_o(paused), .restart_o(rst_p), .error_clear_o(clr_p),
        .home_start_o(home_p)
    );

    host_panel #(.HOME_IDX(1)) host (
        .clk_i(clk_i), .want_i(want), .servo_on_i(servo), .rogue_i(rogue), .port_o(port)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic pop_chk(input string nm, input logic [33:0] s, ref logic [33:0] q[$]);
        if (q.size() == 0) chk(nm, s, 'x);
        else chk(nm, s, q.pop_front());
    endtask : pop_chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    task automatic ex(input logic [6:0] v);
        eq.push_back({27'h0, v});
    endtask : ex

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back({32'h0, r});
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hf;
        req.bready  <= 1'b1;
        do @(posedge clk_i); while (rsp.awready !== 1'b1 || rsp.wready !== 1'b1);
        req.awvalid <= 1'b0;
        req.wvalid  <= 1'b0;
        do @(posedge clk_i); while (rsp.bvalid !== 1'b1);
        req.bready  <= 1'b0;
        // Let an edge pass so a following call never re-drives bready in this step
        @(posedge clk_i);
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do @(posedge clk_i); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge clk_i); while (rsp.rvalid !== 1'b1);
        req.rready  <= 1'b0;
        @(posedge clk_i);
    endtask : axr

    task automatic pin(input int i, input logic v, input int n = 8);
        want[i] <= v;
        cyc(n);
    endtask : pin

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim

    // ****************************************************************
    // Clock, monitor and watchdog
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Every change of the output vector consumes one note
    always @(posedge clk_i) begin
        if (ov !== prev) begin
            pop_chk("outputs", {27'h0, ov}, eq);
            prev = ov;
        end
        if (rsp.bvalid && req.bready) pop_chk("bresp", {32'h0, rsp.bresp}, bq);
        if (rsp.rvalid && req.rready) pop_chk("rdata", {rsp.rresp, rsp.rdata}, rq);
    end

    // Whole sequence needs well under 2000 cycles
    initial begin
        #20000;
        n_errors++;
        end_sim();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        req = '0;
        want = 8'h40;
        auto_mode = 1'b1;
        board_err = 1'b0;
        rogue = 1'b0;
        sys_rst_i = 1'b1;
        ex(7'b0010000);
        cyc(20);
        sys_rst_i <= 1'b0;
        cyc(4);
        axr(ADDR_CTRL, 32'h3, RESP_OKAY);
        axr(ADDR_FSEL_LO, 32'h0, RESP_OKAY);
        axr(8'h10, 32'h0, RESP_SLVERR);
        ex(7'b1010000);
        board_err <= 1'b1;
        cyc(6);
        ex(7'b0010000);
        axw(ADDR_CTRL, 32'h2, RESP_OKAY);
        cyc(6);
        ex(7'b1010000);
        axw(ADDR_CTRL, 32'h3, RESP_OKAY);
        cyc(6);
        ex(7'b0010000);
        board_err <= 1'b0;
        cyc(6);
        axw(ADDR_FSEL_LO, 32'h03101204, RESP_OKAY);
        axw(ADDR_FSEL_HI, 32'h63070805, RESP_OKAY);
        axw(8'h20, 32'h0, RESP_SLVERR);
        axw(ADDR_STATUS, 32'hff, RESP_OKAY);
        axr(ADDR_FSEL_HI, 32'h63070805, RESP_OKAY);
        axr(ADDR_STATUS, 32'h00004002, RESP_OKAY);
        // Start input is ignored while auto start is set
        pin(4, 1'b1);
        pin(4, 1'b0);
        axw(ADDR_CTRL, 32'h1, RESP_OKAY);
        pin(4, 1'b1);
        ex(7'b0000000);
        pin(4, 1'b0);
        ex(7'b0010000);
        pin(4, 1'b1);
        ex(7'b0000000);
        pin(4, 1'b0);
        // Homing with the servo off must be dropped
        rogue <= 1'b1;
        pin(1, 1'b1);
        pin(1, 1'b0);
        rogue <= 1'b0;
        ex(7'b0100000);
        pin(0, 1'b1);
        ex(7'b0100001);
        ex(7'b0100000);
        pin(1, 1'b1);
        pin(1, 1'b0);
        ex(7'b0100010);
        ex(7'b0100000);
        pin(2, 1'b1);
        pin(2, 1'b0);
        ex(7'b0101000);
        pin(6, 1'b0);
        pin(6, 1'b1);
        ex(7'b0100000);
        pin(5, 1'b1);
        pin(5, 1'b0);
        // Noise on a port with an unassigned code
        repeat (20) begin
            want[7] <= 1'($random(seed));
            cyc(1);
        end
        pin(7, 1'b0, 6);
        // A pulse shorter than the hold time must not restart
        pin(3, 1'b1, 10);
        pin(3, 1'b0);
        axw(ADDR_CTRL, 32'h3, RESP_OKAY);
        ex(7'b0000100);
        ex(7'b0010000);
        pin(3, 1'b1, 40);
        pin(3, 1'b0, 10);
        // Outside automatic mode a restart must not relaunch the program
        auto_mode <= 1'b0;
        ex(7'b0000100);
        ex(7'b0000000);
        pin(3, 1'b1, 40);
        pin(3, 1'b0, 10);
        chk("queues", 34'(eq.size() + bq.size() + rq.size()), 34'h0);
        end_sim();
    end
endmodule : input_function_dispatcher_tb
